// ==== ddwl_top.sv ====
// Purpose: Write-leveling training logic inside a DDR3 device
// Assumes: Command struct comes from same-clock decode logic;
//          CK, DQS and ODT are pin levels sampled by clk_i
// Notes: Undefined DQ drive is modelled as driven low
//
// Overview of operation
// RL1: MR1 A7 set enters, cleared leaves leveling
// RL2: ODT switches only strobe termination while leveling
// RL3: MR1 A12 high disables the data drivers
// RL4: Controller limits nominal termination with drivers on
// RL5: DQ drive undefined after entry until feedback
// RL6: Controller sends only NOP/Deselect and exit MRS
// RL7: Controller trains one rank, others A12 high
// RL8: ODT honoured only tMOD after enabling command
// RL9: Strobe termination applied within tWLDQSEN of ODT
// RL10: Controller sends single rising strobe per attempt
// RL11: Sample CK on strobe rise, drive within tWLO
// RL12: Controller steps delay, locks on 0-to-1 change
// RL13: Prime-only feedback drives other DQs low
// RL14: DQ undefined until tMOD after exit command
// RL15: Controller drops ODT before the exit command
// RL16: Controller waits tMOD or tMRD after exit
// RL17: Each byte lane reports its own strobe
// RL18: Feedback is one for CK high, zero low
`timescale 1ns/1ns
`include "ddwl_defines.svh"
module ddwl_top
    import ddwl_pkg::*;
#(
    parameter int LANES = 2,
    parameter int LANE_W = 8,
    parameter bit ALL_DQ = 1'b0,
    parameter int TMOD_CYC = `DDWL_TMOD_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Command pins, same clock domain
    input wire ddwl_cmd_t cmd_i,
    // Link pins sampled by clk_i
    input wire logic ck_i,
    input wire logic odt_i,
    input wire logic [LANES-1:0] dqs_i,
    // Data pins, output half of the two-way DQ
    output logic [LANES*LANE_W-1:0] dq_o,
    output logic [LANES*LANE_W-1:0] dq_oe_o,
    // Termination controls
    output logic [LANES-1:0] dqs_term_o,
    output logic dq_term_o,
    // Leveling mode status
    output logic wl_active_o
);

    localparam int DQ_W = LANES * LANE_W;
    localparam int SYNC_W = LANES + 2;
    localparam int TWLDQSEN_CYC = `DDWL_TWLDQSEN_CYC;
    localparam int TWLO_CYC = `DDWL_TWLO_CYC;
    localparam int EXIT_MAX = TMOD_CYC + 2;

    logic [1:0] rst_sync_r; // Reset release chain
    logic rst_n; // Released reset used everywhere
    logic [SYNC_W-1:0] pins_s; // Synchronised CK, ODT and strobes
    logic ck_s; // CK level, aligned with strobes
    logic odt_s; // ODT level
    logic [LANES-1:0] dqs_s; // Strobe levels
    logic [LANES-1:0] dqs_d_r; // Previous strobe levels
    logic [LANES-1:0] dqs_rise; // One-cycle rising strobe edge
    ddwl_state_t st_r; // Operating state
    ddwl_state_t st_nxt; // Next operating state
    logic qoff_r; // Output buffer disabled
    logic qoff_nxt; // Next output buffer setting
    logic [15:0] mod_cnt_r; // Cycles left of tMOD
    logic [15:0] mod_cnt_nxt; // Next tMOD count
    logic [LANES-1:0] fb_r; // Latched CK samples per lane
    logic is_mrs; // Command is a mode register set
    logic mr1_wr; // Mode register set aimed at MR1
    logic wl_bit; // Leveling bit of the MR1 write
    logic odt_ok; // ODT may act on termination
    logic [DQ_W-1:0] dq_nxt; // Next DQ values
    logic [DQ_W-1:0] oe_nxt; // Next DQ enables
    logic [LANES-1:0] dqs_term_nxt; // Next strobe termination
    logic dq_term_nxt; // Next DQ termination

    // Mode register set is all four command pins low
    function automatic logic cmd_is_mrs(input ddwl_cmd_t c);
        cmd_is_mrs = !c.cs_n && !c.ras_n && !c.cas_n && !c.we_n;
    endfunction

    // Reset asserts at once, releases after two clean edges
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // All pin levels share the same delay so CK and strobes stay aligned
    ddwl_sync #(
        .W(SYNC_W)
    ) u_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .d_i({dqs_i, odt_i, ck_i}),
        .q_o(pins_s)
    );
    assign ck_s = pins_s[0];
    assign odt_s = pins_s[1];
    assign dqs_s = pins_s[SYNC_W-1:2];

    // Command decode
    assign is_mrs = cmd_is_mrs(cmd_i);
    assign mr1_wr = is_mrs && (cmd_i.ba == `DDWL_MR1_BA);
    assign wl_bit = cmd_i.addr[`DDWL_MR1_WL_BIT];
    // Only MR1 writes steer this block; other commands are not expected
    // while leveling and are ignored here
    assign qoff_nxt = mr1_wr ? cmd_i.addr[`DDWL_MR1_QOFF_BIT] : qoff_r; // RL3 RL6

    // State transitions on MR1 writes, exit waits out tMOD
    always_comb begin
        st_nxt = st_r;
        mod_cnt_nxt = (mod_cnt_r != 16'h0) ? mod_cnt_r - 16'h1 : 16'h0;
        // Every MR1 write restarts the tMOD window
        if (mr1_wr) begin
            mod_cnt_nxt = 16'(TMOD_CYC);
        end
        unique case (st_r)
            DDWL_ST_NORMAL: begin
                if (mr1_wr && wl_bit) begin
                    st_nxt = DDWL_ST_LEVEL; // RL1
                end
            end
            DDWL_ST_LEVEL: begin
                if (mr1_wr && !wl_bit) begin
                    st_nxt = DDWL_ST_EXIT; // RL1 RL14
                end
            end
            DDWL_ST_EXIT: begin
                // A fresh enable wins over the running exit window
                if (mr1_wr && wl_bit) begin
                    st_nxt = DDWL_ST_LEVEL; // RL1
                end else if (!mr1_wr && mod_cnt_r <= 16'h1) begin
                    st_nxt = DDWL_ST_NORMAL; // RL14
                end
            end
            // Spare code is never entered; recover to normal mode
            default: begin
                st_nxt = DDWL_ST_NORMAL;
            end
        endcase
    end

    // Mode state registers
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= DDWL_ST_NORMAL;
            qoff_r <= `DDWL_QOFF_RST;
            mod_cnt_r <= 16'h0;
        end else begin
            st_r <= st_nxt;
            qoff_r <= qoff_nxt;
            mod_cnt_r <= mod_cnt_nxt;
        end
    end

    // Strobe edges and CK samples, one per lane
    assign dqs_rise = dqs_s & ~dqs_d_r;
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            // Each lane latches CK on its own strobe only
            always_ff @(posedge clk_i or negedge rst_n) begin
                if (!rst_n) begin
                    dqs_d_r[g] <= 1'b0;
                    fb_r[g] <= 1'b0;
                end else begin
                    dqs_d_r[g] <= dqs_s[g];
                    if (st_r != DDWL_ST_LEVEL) begin
                        fb_r[g] <= 1'b0; // Low until feedback begins, RL5
                    end else if (dqs_rise[g]) begin
                        fb_r[g] <= ck_s; // RL11 RL17 RL18
                    end
                end
            end
            // Prime bit carries feedback, rest follow it or stay low
            assign dq_nxt[g*LANE_W] = (st_r == DDWL_ST_LEVEL) && fb_r[g]; // RL11
            assign dq_nxt[g*LANE_W+LANE_W-1:g*LANE_W+1] = (ALL_DQ && st_r == DDWL_ST_LEVEL) ?
                {(LANE_W-1){fb_r[g]}} : '0; // RL13
        end
    endgenerate

    // Drivers on through leveling and its exit window unless disabled
    assign oe_nxt = (st_r != DDWL_ST_NORMAL && !qoff_r) ? '1 : '0; // RL3 RL5 RL14
    // ODT is ignored until tMOD after the enabling command
    assign odt_ok = odt_s && (mod_cnt_r == 16'h0 || st_r != DDWL_ST_LEVEL); // RL8
    // Leveling terminates strobes only; normal mode terminates both
    assign dqs_term_nxt = odt_ok ? '1 : '0; // RL2 RL9
    assign dq_term_nxt = odt_ok && (st_r == DDWL_ST_NORMAL); // RL2

    // Output registers
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            dq_o <= '0;
            dq_oe_o <= '0;
            dqs_term_o <= '0;
            dq_term_o <= 1'b0;
            wl_active_o <= 1'b0;
        end else begin
            dq_o <= dq_nxt;
            dq_oe_o <= oe_nxt;
            dqs_term_o <= dqs_term_nxt;
            dq_term_o <= dq_term_nxt;
            wl_active_o <= (st_r == DDWL_ST_LEVEL);
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n);

    // Entry and exit steps of the MR1 leveling bit
    sequence s_enter;
        mr1_wr && wl_bit;
    endsequence
    sequence s_leave;
        mr1_wr && !wl_bit && st_r == DDWL_ST_LEVEL;
    endsequence

    a_wl_enter: assert property (s_enter |-> ##2 wl_active_o) // RL1
        else $error("Leveling not entered after MR1 A7 set");
    a_wl_leave: assert property (s_leave |-> ##2 !wl_active_o) // RL1
        else $error("Leveling not left after MR1 A7 clear");
    a_dq_term_off: assert property (wl_active_o |-> !dq_term_o) // RL2
        else $error("DQ termination on while leveling");
    // An early ODT is held off by tMOD, which still fits inside tWLDQSEN
    a_term_follow: assert property (st_r == DDWL_ST_LEVEL && // RL9
        $rose(odt_s) |-> ##[1:TWLDQSEN_CYC] dqs_term_o == '1)
        else $error("Strobe termination late after ODT");
    a_qoff_drv: assert property (qoff_r |=> dq_oe_o == '0) // RL3
        else $error("Drivers on with output buffer disabled");
    a_entry_drive: assert property (s_enter ##1 (!qoff_r && st_r == DDWL_ST_LEVEL) // RL5
        |=> dq_oe_o == '1)
        else $error("DQ not driven after leveling entry");
    a_fb_value: assert property (st_r == DDWL_ST_LEVEL && dqs_rise[0] ##1 // RL11 RL18
        st_r == DDWL_ST_LEVEL |=> dq_o[0] == $past(ck_s, 2))
        else $error("Lower lane feedback differs from sampled CK");
    a_fb_time: assert property (st_r == DDWL_ST_LEVEL && dqs_rise[0] ##1 // RL11
        st_r == DDWL_ST_LEVEL |-> ##[1:TWLO_CYC] dq_o[0] == fb_r[0])
        else $error("Feedback not presented in time");
    a_upper_lane: assert property (st_r == DDWL_ST_LEVEL && dqs_rise[LANES-1] ##1 // RL17
        st_r == DDWL_ST_LEVEL |=> dq_o[(LANES-1)*LANE_W] == $past(ck_s, 2))
        else $error("Upper lane feedback differs from sampled CK");
    a_prime_low: assert property (!ALL_DQ |-> // RL13
        (dq_o & ~{LANES{{(LANE_W-1){1'b0}}, 1'b1}}) == '0)
        else $error("Non-prime DQ not low in prime-only mode");
    a_exit_window: assert property (s_leave |-> ##[1:EXIT_MAX] st_r == DDWL_ST_NORMAL) // RL14
        else $error("Exit window does not close after tMOD");

endmodule

// ==== ddwl_defines.svh ====
// Purpose: Constants for the DDR3 write-leveling device logic
// Assumes: Core clock of 50 MHz
// Notes: Times are in ns, cycle counts are derived from them
`ifndef DDWL_DEFINES_SVH
`define DDWL_DEFINES_SVH

// Core clock period in ns
`define DDWL_CLK_NS 20
// Mode register index of MR1 on the bank address pins
`define DDWL_MR1_BA 3'h1
// MR1 field positions
`define DDWL_MR1_WL_BIT 7
`define DDWL_MR1_QOFF_BIT 12
// Reset values of the mode bits
`define DDWL_WL_RST 1'h0
`define DDWL_QOFF_RST 1'h0
// Mode register command delay, a least time (round up)
`define DDWL_TMOD_NS 240
`define DDWL_TMOD_CYC ((`DDWL_TMOD_NS + `DDWL_CLK_NS - 1) / `DDWL_CLK_NS)
// Strobe termination enable delay, a longest time (round down)
`define DDWL_TWLDQSEN_NS 500
`define DDWL_TWLDQSEN_CYC (`DDWL_TWLDQSEN_NS / `DDWL_CLK_NS)
// Feedback output delay, a longest time (round down)
`define DDWL_TWLO_NS 80
`define DDWL_TWLO_CYC (`DDWL_TWLO_NS / `DDWL_CLK_NS)

`endif

// ==== ddwl_pkg.sv ====
// Purpose: Types shared by the write-leveling device logic
// Assumes: Nothing beyond the constants header
// Notes: Command fields travel together as one packed struct
package ddwl_pkg;

    // Command pins as seen by the device, one cycle per command
    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [2:0] ba;
        logic [15:0] addr;
    } ddwl_cmd_t;

    // Device operating state around leveling
    typedef enum logic [1:0] {
        DDWL_ST_NORMAL = 2'b00,
        DDWL_ST_LEVEL = 2'b01,
        DDWL_ST_EXIT = 2'b10
    } ddwl_state_t;

endpackage

// ==== ddwl_sync.sv ====
// Purpose: Two-flop synchroniser for a bundle of level inputs
// Assumes: Bits are independent levels, no word coherence needed
// Notes: First stage feeds only the second stage
`timescale 1ns/1ns
module ddwl_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Asynchronous levels in, synchronised levels out
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);

    logic [W-1:0] meta_r; // First stage, read only by the second

    // Two stages give metastability time to settle
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_r <= '0;
            q_o <= '0;
        end else begin
            meta_r <= d_i;
            q_o <= meta_r;
        end
    end

endmodule

// ==== ddwl_ctrl_model.sv ====
// Purpose: Memory controller model for write-leveling training
// Assumes: Strobe delay is counted in core clocks after a CK rise
// Notes: CK runs free, eight core clocks per period (160 ns)
`timescale 1ns/1ns
module ddwl_ctrl_model (
    // Core clock of the bench
    input wire logic clk_i,
    // Link pins towards the device
    output logic ck_o,
    output logic odt_o,
    output logic [1:0] dqs_o
);
    // Free running CK, toggled off the core clock edge
    initial begin
        ck_o = 1'h0;
        odt_o = 1'h0;
        dqs_o = 2'h0;
        forever begin
            repeat (4) @(posedge clk_i);
            #1 ck_o = ~ck_o;
        end
    end

    // Termination request; the caller owns the tMOD spacing
    task automatic set_odt(input logic v);
        @(posedge clk_i);
        #1 odt_o = v;
    endtask

    // One single rising strobe d clocks after a CK rise, then back low
    task automatic strobe(input int lane, input int d);
        @(posedge ck_o);
        repeat (d) @(posedge clk_i);
        #1 dqs_o[lane] = 1'h1;
        repeat (3) @(posedge clk_i);
        #1 dqs_o[lane] = 1'h0;
    endtask
endmodule

// ==== ddr3_write_leveling_test.sv ====
// Purpose: Self-checking bench for the write-leveling device logic
// Assumes: Default tMOD count, controller model drives the link pins
// Notes: Undefined DQ drive is expected as driven low
`timescale 1ns/1ns
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; \
    $display("unexpected %s exp %h got %h", n, e, g); end end
module ddr3_write_leveling_test import ddwl_pkg::*; ;
    localparam int TMOD = 12; // Mode register delay in core clocks
    logic clk_i;
    logic nrst_i;
    ddwl_cmd_t cmd_i; // Command pins, NOP when idle
    logic ck;
    logic odt;
    logic [1:0] dqs;
    logic [15:0] dq;
    logic [15:0] dq_oe;
    logic [1:0] dqs_term;
    logic dq_term;
    logic wl_act;
    logic [15:0] exp_dq; // Expected feedback word across both lanes
    logic [15:0] dq_all; // DQ of the variant that repeats feedback on all bits
    int errors = 0;
    int tests_run = 0;

    ddwl_top #(.TMOD_CYC(TMOD)) ddwl_top_i (.clk_i(clk_i), .nrst_i(nrst_i), .cmd_i(cmd_i),
        .ck_i(ck), .odt_i(odt), .dqs_i(dqs), .dq_o(dq), .dq_oe_o(dq_oe),
        .dqs_term_o(dqs_term), .dq_term_o(dq_term), .wl_active_o(wl_act));
    // Second device built to drive feedback on every DQ of a lane
    ddwl_top #(.TMOD_CYC(TMOD), .ALL_DQ(1'b1)) ddwl_top_all_i (.clk_i(clk_i),
        .nrst_i(nrst_i), .cmd_i(cmd_i), .ck_i(ck), .odt_i(odt), .dqs_i(dqs),
        .dq_o(dq_all), .dq_oe_o(), .dqs_term_o(), .dq_term_o(), .wl_active_o());
    ddwl_ctrl_model ddwl_ctrl_model_i (.clk_i(clk_i), .ck_o(ck), .odt_o(odt), .dqs_o(dqs));

    // 50 MHz core clock
    initial begin
        clk_i = 1'h0;
        forever #10 clk_i = ~clk_i;
    end

    // Wait n edges, then step past the edge so outputs have settled
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // One-cycle mode register set, NOP after, returns where outputs answer
    task automatic mrs(input logic [2:0] ba, input logic wl, input logic qoff);
        ddwl_cmd_t c;
        // Termination code bits are not decoded by the block and stay cleared
        c = '{1'h0, 1'h0, 1'h0, 1'h0, ba, 16'h0};
        c.addr[7] = wl;
        c.addr[12] = qoff;
        @(posedge clk_i);
        #1 cmd_i = c;
        @(posedge clk_i);
        #1 cmd_i = '{1'h1, 1'h1, 1'h1, 1'h1, 3'h0, 16'h0};
        cyc(2);
    endtask

    task automatic t_reset();
        cyc(5);
        `CHK("wl_active", 1'h0, wl_act);
        `CHK("dq_oe", 16'h0, dq_oe);
    endtask

    // Normal mode: ODT drives both terminations; other mode registers ignored
    task automatic t_normal();
        ddwl_ctrl_model_i.set_odt(1'h1);
        cyc(5);
        `CHK("dq_term", 1'h1, dq_term);
        mrs(3'h0, 1'h1, 1'h0);
        `CHK("wl_active", 1'h0, wl_act);
        ddwl_ctrl_model_i.set_odt(1'h0);
        cyc(5);
    endtask

    // Entry with drivers on; early ODT must wait out tMOD
    task automatic t_entry();
        mrs(3'h1, 1'h1, 1'h0);
        `CHK("wl_active", 1'h1, wl_act);
        `CHK("dq_oe", 16'hffff, dq_oe);
        `CHK("dq", 16'h0, dq);
        `CHK("dq_all", 16'h0, dq_all);
        ddwl_ctrl_model_i.set_odt(1'h1);
        cyc(3);
        `CHK("dqs_term", 2'h0, dqs_term);
        cyc(10);
        `CHK("dqs_term", 2'h3, dqs_term);
        `CHK("dq_term", 1'h0, dq_term);
        cyc(25);
        exp_dq = 16'h0;
    endtask

    // Delay search on one lane: feedback per strobe, lock on 0 to 1
    task automatic t_search(input int lane);
        int lock;
        logic prev;
        lock = 0;
        prev = 1'h1;
        for (int d = 5; d <= 9; d++) begin
            ddwl_ctrl_model_i.strobe(lane, d);
            cyc(3);
            exp_dq[lane*8] = ((d % 8) < 4) ? 1'h1 : 1'h0;
            `CHK("dq", exp_dq, dq);
            `CHK("dq_all", {{8{exp_dq[8]}}, {8{exp_dq[0]}}}, dq_all);
            if (prev === 1'h0 && dq[lane*8] === 1'h1 && lock == 0) begin
                lock = d;
            end
            prev = dq[lane*8];
        end
        `CHK("lock", 8, lock);
    endtask

    // Exit: ODT low first, then clear leveling
    task automatic t_exit();
        ddwl_ctrl_model_i.set_odt(1'h0);
        cyc(5);
        `CHK("dqs_term", 2'h0, dqs_term);
        mrs(3'h1, 1'h0, 1'h0);
        `CHK("wl_active", 1'h0, wl_act);
        `CHK("dq", 16'h0, dq);
        `CHK("dq_all", 16'h0, dq_all);
        `CHK("dq_oe", 16'hffff, dq_oe);
        cyc(TMOD);
        `CHK("dq_oe", 16'h0, dq_oe);
    endtask

    // Drivers off for a rank that is not being trained
    task automatic t_qoff();
        mrs(3'h1, 1'h1, 1'h1);
        `CHK("wl_active", 1'h1, wl_act);
        `CHK("dq_oe", 16'h0, dq_oe);
        mrs(3'h1, 1'h0, 1'h1);
        cyc(TMOD);
        `CHK("wl_active", 1'h0, wl_act);
    endtask

    // Verdict and end of run
    task automatic test_done();
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Main sequence, reset held ten clocks
    initial begin
        nrst_i = 1'h0;
        cmd_i = '{1'h1, 1'h1, 1'h1, 1'h1, 3'h0, 16'h0};
        exp_dq = 16'h0;
        repeat (10) @(posedge clk_i);
        #1 nrst_i = 1'h1;
        t_reset();
        t_normal();
        t_entry();
        t_search(0);
        t_search(1);
        t_exit();
        t_qoff();
        test_done();
    end

    // Watchdog, about thirty-five times the expected run
    initial begin
        #200000;
        errors++;
        test_done();
    end
endmodule
